/* logic/monitor_pkg.sv */
// Shared constants, register map and carrier types for the input channel monitor
package monitor_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int QUS_NS = 250;
  localparam int QUS_CYC = (QUS_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CMD = 8'h04;
  localparam logic [7:0] ADR_SPEED = 8'h08;
  localparam logic [7:0] ADR_ERR = 8'h0c;
  localparam logic [7:0] ADR_VIN_TH = 8'h10;
  localparam logic [7:0] ADR_TEMP_TH = 8'h14;
  localparam logic [7:0] ADR_PER_TH = 8'h18;
  localparam logic [7:0] ADR_UPTIME = 8'h1c;
  localparam logic [7:0] ADR_BAUD = 8'h20;
  localparam logic [7:0] ADR_PERIOD = 8'h24;
  localparam logic [7:0] ADR_VIN = 8'h28;
  localparam logic [7:0] ADR_TEMP = 8'h2c;
  localparam logic [7:0] ADR_STAT = 8'h40;
  localparam logic [3:0] PG_CHAN = 4'h3;
  localparam logic [3:0] PG_LIM = 4'h5;
  localparam logic [3:0] PG_NEUT = 4'h6;
  localparam logic [3:0] PG_GAIN = 4'h7;
  localparam logic [2:0] PG_CNT = 3'h4;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_SS_BIT = 2;
  localparam int CTRL_DISC_BIT = 3;
  localparam int CTRL_SPEED_LSB = 4;
  localparam int CTRL_KILL_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000000c;
  localparam int CMD_RESUME_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam logic [1:0] MODE_SERIAL = 2'h0;
  localparam logic [1:0] MODE_ANALOG = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h2;
  localparam logic [2:0] ST_VALID = 3'h0;
  localparam logic [2:0] ST_DISC = 3'h1;
  localparam logic [2:0] ST_BADSIG = 3'h2;
  localparam logic [2:0] ST_HIGH = 3'h3;
  localparam logic [2:0] ST_LOW = 3'h4;
  localparam int NUM_ERR = 6;
  localparam int E_SAFE = 0;
  localparam int E_REQ = 1;
  localparam int E_KILL = 2;
  localparam int E_VLOW = 3;
  localparam int E_VHIGH = 4;
  localparam int E_TEMP = 5;
  // Full scale 3200, neutral band 8 %, switch level 50 %
  localparam logic signed [25:0] FULL_SCALE = 26'sh0000c80;
  localparam logic [17:0] NEUTRAL_BAND = 18'h00100;
  localparam logic signed [15:0] KILL_LEVEL = 16'sh0640;
  localparam logic [11:0] DISC_LEVEL = 12'hc00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_s;
  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [11:0] data;
  } adc_s;
  typedef enum logic [3:0] {
    BAUD_IDLE = 4'b0001,
    BAUD_LOW = 4'b0010,
    BAUD_HIGH = 4'b0100,
    BAUD_LOCK = 4'b1000
  } baud_e;
endpackage

/* logic/motor_input_channel_monitor.sv */
// Input channel monitor: pulse and analog readout, scaling, validity, conditions, errors
//
// Behaviour
// - Pulse width stored in quarter microseconds
// - Analog average held as 12-bit code
// - Scaled value from raw and settings, +-3200
// - Analog outside error limits flagged high/low
// - Pulse width outside limits flagged high/low
// - Missing or bad-period pulses flag invalid signal
// - Toggle analog supply to detect disconnection
// - Supply voltage outside thresholds stops motor
// - Over-temperature stops the motor
// - Up time counts from reset and wraps
// - Baud measured from 0xAA, unknown until locked
// - First pulse period, unavailable when invalid
// - Manual speed only in serial mode, no error
// - Error output high while error stops motor
// - Running count per error type
// - Active error flags readable by host
// - Safe start enabled after reset
// - Analog/pulse mode clears safe start near neutral
// - Required channel invalid raises error
// - Switch channel active above half scale
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module motor_input_channel_monitor #(
  parameter int MS_CYCLES = monitor_pkg::MS_CYC
) (
  input logic sys_clk,
  input logic resetn,
  input monitor_pkg::wb_req_s wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic pulse_input_one,
  input logic pulse_input_two,
  input logic serial_rx,
  input monitor_pkg::adc_s adc_i,
  output logic analog_supply_on,
  output logic error_out,
  output logic [15:0] target_speed
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [31:0] ctrl;
    logic [31:0] vin_th;
    logic [11:0] temp_th;
    logic [31:0] per_th;
    logic [3:0][31:0] lim;
    logic [3:0][15:0] neut;
    logic [3:0][31:0] gain;
    logic [3:0][15:0] raw;
    logic [3:0][15:0] scl;
    logic [3:0][2:0] stat;
    logic [3:0][13:0] acc;
    logic [2:0] meta;
    logic [2:0] sync;
    logic [2:0] prev;
    logic [4:0] qdiv;
    logic [1:0][15:0] wid;
    logic [1:0][19:0] per;
    logic [1:0] bad;
    logic [19:0] period;
    logic [31:0] msdiv;
    logic [31:0] up;
    logic supply;
    logic [1:0] disc;
    monitor_pkg::baud_e bst;
    logic [15:0] bcnt;
    logic [15:0] blow;
    logic [15:0] baud;
    logic [5:0] err;
    logic [5:0][15:0] cnt;
    logic ss;
    logic [15:0] speed;
    logic errout;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic [3:0][15:0] scl_w;
  logic [3:0][2:0] stat_w;
  logic [3:0][15:0] abs_w;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++)
      merge[8*b+:8] = sel[b] ? n[8*b+:8] : o[8*b+:8];
  endfunction

  // ----------------------------------------------------------------
  // Per-channel scaling and status
  // ----------------------------------------------------------------
  // A single gain per side stands in for the min and max points: software
  // loads 3200*256/(max-neutral) and avoids a divider here.
  for (genvar i = 0; i < 4; i++)
  begin : g_chan
    logic signed [16:0] diff;
    logic [15:0] g;
    logic signed [33:0] prod;
    logic signed [25:0] sh;
    logic [15:0] lo;
    logic [15:0] hi;
    assign diff = $signed({1'b0, s_q.raw[i]}) - $signed({1'b0, s_q.neut[i]});
    assign g = diff < 0 ? s_q.gain[i][31:16] : s_q.gain[i][15:0];
    assign prod = diff * $signed({1'b0, g});
    assign sh = prod[33:8];
    assign scl_w[i] = sh > monitor_pkg::FULL_SCALE ? monitor_pkg::FULL_SCALE[15:0] :
                      sh < -monitor_pkg::FULL_SCALE ? 16'(-monitor_pkg::FULL_SCALE) :
                      sh[15:0];
    assign abs_w[i] = s_q.scl[i][15] ? 16'(-s_q.scl[i]) : s_q.scl[i];
    assign lo = s_q.lim[i][15:0];
    assign hi = s_q.lim[i][31:16];
    if (i < 2)
    begin : g_pulse
      assign stat_w[i] = s_q.bad[i] ? monitor_pkg::ST_BADSIG :
                         s_q.raw[i] > hi ? monitor_pkg::ST_HIGH :
                         s_q.raw[i] < lo ? monitor_pkg::ST_LOW :
                         monitor_pkg::ST_VALID;
    end
    else
    begin : g_analog
      assign stat_w[i] = s_q.disc[i-2] ? monitor_pkg::ST_DISC :
                         s_q.raw[i] > hi ? monitor_pkg::ST_HIGH :
                         s_q.raw[i] < lo ? monitor_pkg::ST_LOW :
                         monitor_pkg::ST_VALID;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic req;
    logic wr;
    logic resume;
    logic stop_cmd;
    logic spd_wr;
    logic rise;
    logic fall;
    logic other;
    logic serial;
    logic [7:0] a;
    logic [3:0] reqm;
    logic [3:0] inval;
    logic [3:0] kill;
    logic [17:0] sumabs;
    logic [19:0] pmin;
    logic [19:0] pmax;
    logic [16:0] hi2;
    logic [16:0] lo17;
    logic [5:0] e;
    logic [31:0] rd;
    req = 1'b0;
    wr = 1'b0;
    resume = 1'b0;
    stop_cmd = 1'b0;
    spd_wr = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    other = 1'b0;
    serial = 1'b0;
    a = 8'h00;
    reqm = 4'h0;
    inval = 4'h0;
    kill = 4'h0;
    sumabs = 18'h00000;
    pmin = 20'h00000;
    pmax = 20'h00000;
    hi2 = 17'h00000;
    lo17 = 17'h00000;
    e = 6'h00;
    rd = 32'h00000000;
    s_d = s_q;

    // Wishbone slave: one-cycle answer, ack low for a cycle in between
    req = wb_i.cyc & wb_i.stb & ~s_q.ack;
    wr = req & wb_i.we;
    a = {wb_i.adr[7:2], 2'b00};
    s_d.ack = req;
    if (wr)
    begin
      case (a)
        monitor_pkg::ADR_CTRL: s_d.ctrl = merge(s_q.ctrl, wb_i.dat, wb_i.sel);
        monitor_pkg::ADR_CMD:
        begin
          resume = wb_i.sel[0] & wb_i.dat[monitor_pkg::CMD_RESUME_BIT];
          stop_cmd = wb_i.sel[0] & wb_i.dat[monitor_pkg::CMD_STOP_BIT];
        end
        monitor_pkg::ADR_SPEED: spd_wr = 1'b1;
        monitor_pkg::ADR_VIN_TH: s_d.vin_th = merge(s_q.vin_th, wb_i.dat, wb_i.sel);
        monitor_pkg::ADR_TEMP_TH:
          s_d.temp_th = 12'(merge({20'h0, s_q.temp_th}, wb_i.dat, wb_i.sel));
        monitor_pkg::ADR_PER_TH: s_d.per_th = merge(s_q.per_th, wb_i.dat, wb_i.sel);
        default:
        begin
          if (a[7:4] == monitor_pkg::PG_LIM)
            s_d.lim[a[3:2]] = merge(s_q.lim[a[3:2]], wb_i.dat, wb_i.sel);
          if (a[7:4] == monitor_pkg::PG_NEUT)
            s_d.neut[a[3:2]] = 16'(merge({16'h0, s_q.neut[a[3:2]]}, wb_i.dat, wb_i.sel));
          if (a[7:4] == monitor_pkg::PG_GAIN)
            s_d.gain[a[3:2]] = merge(s_q.gain[a[3:2]], wb_i.dat, wb_i.sel);
        end
      endcase
    end
    case (a)
      monitor_pkg::ADR_CTRL: rd = s_q.ctrl;
      monitor_pkg::ADR_SPEED: rd = {16'h0000, s_q.speed};
      monitor_pkg::ADR_ERR: rd = {26'h0, s_q.err};
      monitor_pkg::ADR_VIN_TH: rd = s_q.vin_th;
      monitor_pkg::ADR_TEMP_TH: rd = {20'h0, s_q.temp_th};
      monitor_pkg::ADR_PER_TH: rd = s_q.per_th;
      monitor_pkg::ADR_UPTIME: rd = s_q.up;
      monitor_pkg::ADR_BAUD: rd = {16'h0000, s_q.baud};
      monitor_pkg::ADR_PERIOD: rd = s_q.bad[0] ? 32'h0 : {12'h0, s_q.period};
      monitor_pkg::ADR_VIN: rd = {20'h0, s_q.acc[2][13:2]};
      monitor_pkg::ADR_TEMP: rd = {20'h0, s_q.acc[3][13:2]};
      monitor_pkg::ADR_STAT: rd = {20'h0, s_q.stat};
      default:
      begin
        if (a[7:4] == monitor_pkg::PG_CHAN)
          rd = {s_q.scl[a[3:2]], s_q.raw[a[3:2]]};
        if (a[7:4] == monitor_pkg::PG_LIM)
          rd = s_q.lim[a[3:2]];
        if (a[7:4] == monitor_pkg::PG_NEUT)
          rd = {16'h0000, s_q.neut[a[3:2]]};
        if (a[7:4] == monitor_pkg::PG_GAIN)
          rd = s_q.gain[a[3:2]];
        if (a[7:5] == monitor_pkg::PG_CNT && a[4:2] < 3'(monitor_pkg::NUM_ERR))
          rd = {16'h0000, s_q.cnt[a[4:2]]};
      end
    endcase
    s_d.rdat = (req & ~wb_i.we) ? rd : 32'h00000000;

    // Pin synchronisers: pulse one, pulse two, serial receive
    s_d.meta = {serial_rx, pulse_input_two, pulse_input_one};
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;

    // Quarter-microsecond time base
    s_d.qdiv = s_q.qdiv == 5'(monitor_pkg::QUS_CYC - 1) ? 5'h00 : s_q.qdiv + 5'h01;
    pmin = {s_q.per_th[15:0], 4'h0};
    pmax = {s_q.per_th[31:16], 4'h0};
    for (int i = 0; i < 2; i++)
    begin
      rise = s_q.sync[i] & ~s_q.prev[i];
      fall = ~s_q.sync[i] & s_q.prev[i];
      if (s_q.qdiv == 5'h00)
      begin
        if (s_q.sync[i] && s_q.wid[i] != 16'hffff)
          s_d.wid[i] = s_q.wid[i] + 16'h0001;
        if (s_q.per[i] != 20'hfffff)
          s_d.per[i] = s_q.per[i] + 20'h00001;
      end
      if (fall)
      begin
        s_d.raw[i] = s_q.wid[i];
        s_d.wid[i] = 16'h0000;
      end
      if (rise)
      begin
        s_d.bad[i] = s_q.per[i] < pmin || s_q.per[i] > pmax;
        if (i == 0)
          s_d.period = s_q.per[i];
        s_d.per[i] = 20'h00000;
        s_d.wid[i] = 16'h0000;
      end
      else if (s_q.per[i] > pmax)
        s_d.bad[i] = 1'b1;
    end

    // Analog averaging; channel 0 and 1 samples taken with the supply off only probe the pot
    if (adc_i.valid)
    begin
      if (adc_i.chan[1] == 1'b0 && !s_q.supply)
        s_d.disc[adc_i.chan[0]] = adc_i.data > monitor_pkg::DISC_LEVEL;
      else
        s_d.acc[adc_i.chan] = s_q.acc[adc_i.chan] - {2'b00, s_q.acc[adc_i.chan][13:2]}
                              + {2'b00, adc_i.data};
    end
    s_d.raw[2] = {4'h0, s_q.acc[0][13:2]};
    s_d.raw[3] = {4'h0, s_q.acc[1][13:2]};
    s_d.scl = scl_w;
    s_d.stat = stat_w;

    // Millisecond tick: up time and the disconnect probe rhythm
    s_d.msdiv = s_q.msdiv == 32'(MS_CYCLES - 1) ? 32'h0 : s_q.msdiv + 32'h1;
    if (s_q.msdiv == 32'(MS_CYCLES - 1))
    begin
      s_d.up = s_q.up + 32'h1;
      s_d.supply = ~s_q.supply;
    end
    if (!s_q.ctrl[monitor_pkg::CTRL_DISC_BIT])
    begin
      s_d.supply = 1'b1;
      s_d.disc = 2'b00;
    end

    // Auto-baud: start plus bit 0 of 0xAA give a double-width low
    rise = s_q.sync[2] & ~s_q.prev[2];
    fall = ~s_q.sync[2] & s_q.prev[2];
    s_d.bcnt = s_q.bcnt + 16'h0001;
    hi2 = {s_q.bcnt, 1'b0};
    lo17 = {1'b0, s_q.blow};
    case (s_q.bst)
      monitor_pkg::BAUD_IDLE:
      begin
        // The detecting cycle counts, so measured widths come out whole
        s_d.bcnt = fall ? 16'h0001 : 16'h0000;
        if (fall)
          s_d.bst = monitor_pkg::BAUD_LOW;
      end
      monitor_pkg::BAUD_LOW:
      begin
        if (rise)
        begin
          s_d.blow = s_q.bcnt;
          s_d.bcnt = 16'h0001;
          s_d.bst = monitor_pkg::BAUD_HIGH;
        end
      end
      monitor_pkg::BAUD_HIGH:
      begin
        if (fall)
        begin
          s_d.bcnt = 16'h0001;
          if (hi2 >= lo17 - (lo17 >> 2) && hi2 <= lo17 + (lo17 >> 2))
          begin
            s_d.baud = {1'b0, s_q.blow[15:1]};
            s_d.bst = monitor_pkg::BAUD_LOCK;
          end
          else
            s_d.bst = monitor_pkg::BAUD_LOW;
        end
      end
      monitor_pkg::BAUD_LOCK: s_d.bcnt = 16'h0000;
      default: s_d.bst = monitor_pkg::BAUD_IDLE;
    endcase
    if (s_q.bcnt == 16'hffff && s_q.bst != monitor_pkg::BAUD_LOCK)
      s_d.bst = monitor_pkg::BAUD_IDLE;

    // Errors
    serial = s_q.ctrl[1:0] == monitor_pkg::MODE_SERIAL;
    reqm = (serial ? 4'h0 : s_q.ctrl[monitor_pkg::CTRL_SPEED_LSB+:4])
           | s_q.ctrl[monitor_pkg::CTRL_KILL_LSB+:4];
    for (int i = 0; i < 4; i++)
    begin
      inval[i] = s_q.stat[i] != monitor_pkg::ST_VALID;
      kill[i] = $signed(s_q.scl[i]) > monitor_pkg::KILL_LEVEL;
      if (!serial && s_q.ctrl[monitor_pkg::CTRL_SPEED_LSB+i])
        sumabs = sumabs + {2'b00, abs_w[i]};
    end
    e[monitor_pkg::E_REQ] = |(reqm & inval);
    e[monitor_pkg::E_KILL] = |(s_q.ctrl[monitor_pkg::CTRL_KILL_LSB+:4] & kill);
    e[monitor_pkg::E_VLOW] = s_q.acc[2][13:2] < s_q.vin_th[11:0];
    e[monitor_pkg::E_VHIGH] = s_q.acc[2][13:2] > s_q.vin_th[27:16];
    e[monitor_pkg::E_TEMP] = s_q.acc[3][13:2] > s_q.temp_th;
    other = |e;
    // Setting wins over clearing so a fresh fault cannot slip past a resume
    if ((s_q.ctrl[monitor_pkg::CTRL_SS_BIT] && other) || stop_cmd)
      s_d.ss = 1'b1;
    else if (serial ? (resume && !other) : (!other && sumabs < monitor_pkg::NEUTRAL_BAND))
      s_d.ss = 1'b0;
    e[monitor_pkg::E_SAFE] = s_q.ss;
    s_d.err = e;
    for (int k = 0; k < monitor_pkg::NUM_ERR; k++)
      if (e[k] && !s_q.err[k])
        s_d.cnt[k] = s_q.cnt[k] + 16'h0001;
    s_d.errout = |e;

    // Target speed
    if (|e)
      s_d.speed = 16'h0000;
    else if (serial)
    begin
      if (spd_wr && !(|s_q.err))
        s_d.speed = 16'(merge({16'h0, s_q.speed}, wb_i.dat, wb_i.sel));
    end
    else
      s_d.speed = s_q.ctrl[1:0] == monitor_pkg::MODE_PULSE ? s_q.scl[0] : s_q.scl[2];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.ctrl <= monitor_pkg::CTRL_RST;
      s_q.supply <= 1'b1;
      // Receive line idles high: no false edge right after reset
      s_q.meta <= 3'b100;
      s_q.sync <= 3'b100;
      s_q.prev <= 3'b100;
      s_q.bst <= monitor_pkg::BAUD_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign analog_supply_on = s_q.supply;
  assign error_out = s_q.errout;
  assign target_speed = s_q.speed;
endmodule

/* tb/monitor_asserts.sv */
// Port-level checker for the input channel monitor
`timescale 1ns/1ps
module monitor_asserts #(
  parameter int MS_CYCLES = 100000
) (
  input logic sys_clk,
  input logic resetn,
  input monitor_pkg::wb_req_s wb_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic analog_supply_on,
  input logic error_out,
  input logic [15:0] target_speed
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_ack_follows_req: assert property ((wb_i.cyc && wb_i.stb && !wb_ack_o) |=> wb_ack_o)
    else $error("Bus request not acknowledged in the next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held longer than one cycle");
  a_ack_has_req: assert property ($rose(wb_ack_o) |-> $past(wb_i.cyc) && $past(wb_i.stb))
    else $error("Acknowledge without a preceding request");
  a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("Read data not zero outside the acknowledge cycle");
  a_speed_bounded: assert property ($signed(target_speed) >= -16'sd3200 && $signed(target_speed) <= 16'sd3200)
    else $error("Target speed beyond full scale");
  a_err_stops: assert property (error_out [*3] |-> target_speed == 16'h0)
    else $error("Motor speed not zero while an error stands");
  a_err_speed_zero: assert property ($rose(error_out) |-> ##[0:3] target_speed == 16'h0)
    else $error("Speed not dropped soon after error output rose");
  a_reset_quiet: assert property ($rose(resetn) |-> !error_out && target_speed == 16'h0 && analog_supply_on)
    else $error("Outputs not at reset values after reset");

  c_write: cover property (wb_i.we && wb_ack_o);
  c_error: cover property ($rose(error_out));
  c_speed: cover property (target_speed != 16'h0);
endmodule

bind motor_input_channel_monitor monitor_asserts #(.MS_CYCLES(MS_CYCLES)) u_asserts (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .wb_i(wb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .analog_supply_on(analog_supply_on),
  .error_out(error_out),
  .target_speed(target_speed)
);

/* tb/far_side_model.sv */
// Behavioural far side: pulse receiver, analog sources and a serial host
`timescale 1ns/1ps
module far_side_model #(
  parameter int PULSE_W = 1000,
  parameter int PULSE_P = 2500,
  parameter int BIT_CYC = 87
) (
  input logic sys_clk,
  input logic pulse_en,
  input logic adc_en,
  input logic pot_connected,
  input logic aa_go,
  input logic [3:0][11:0] adc_val,
  input logic analog_supply_on,
  output logic pulse_input_one = 1'b0,
  output logic pulse_input_two = 1'b0,
  output logic serial_rx = 1'b1,
  output monitor_pkg::adc_s adc_i = '0
);
  int pcnt = 0;
  logic [1:0] ach = 2'h0;
  logic [9:0] frame = {1'b1, 8'haa, 1'b0};

  always @(posedge sys_clk)
  begin
    pcnt <= (pcnt == PULSE_P - 1) ? 0 : pcnt + 1;
    pulse_input_one <= pulse_en && pcnt < PULSE_W;
    pulse_input_two <= pulse_en && pcnt < PULSE_W / 2;
    ach <= ach + 2'h1;
    adc_i.valid <= adc_en;
    adc_i.chan <= ach;
    // Supply off: a wired pot reads ground, an open input floats to the pull-up
    if (ach < 2'h2 && !analog_supply_on)
      adc_i.data <= pot_connected ? 12'h000 : 12'hfff;
    else
      adc_i.data <= adc_val[ach];
  end

  // Host sends the sync byte once; the line idles high before and after
  initial
  begin
    @(posedge aa_go);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge sys_clk);
      serial_rx <= frame[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk);
    end
  end
endmodule

/* tb/tb.sv */
// Self-checking bench for the input channel monitor
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] val;
    logic [4:0] sh;
    logic [31:0] want;
  } row_s;
  localparam row_s RST_ROWS[7] = '{
    '{8'h00, 32'h0, 5'd0, monitor_pkg::CTRL_RST},
    '{8'h0c, 32'h0, 5'd0, 32'h0},
    '{8'h20, 32'h0, 5'd0, 32'h0},
    '{8'h24, 32'h0, 5'd0, 32'h0},
    '{8'h40, 32'h0, 5'd0, 32'h12},
    '{8'h04, 32'h0, 5'd0, 32'h0},
    '{8'hfc, 32'h0, 5'd0, 32'h0}};
  localparam row_s LIM_ROWS[7] = '{
    '{8'h50, 32'h003c_0014, 5'd0, 32'h0},
    '{8'h50, 32'h001e_0014, 5'd0, 32'h3},
    '{8'h50, 32'h0064_0032, 5'd0, 32'h4},
    '{8'h50, 32'h003c_0014, 5'd0, 32'h0},
    '{8'h58, 32'h0700_0100, 5'd6, 32'h3},
    '{8'h58, 32'h0f00_0900, 5'd6, 32'h4},
    '{8'h58, 32'h0f00_0100, 5'd6, 32'h0}};
  localparam row_s ERR_ROWS[3] = '{
    '{8'h0, 32'h0200_0100, 5'd0, 32'h09},
    '{8'h0, 32'h0e00_0100, 5'd0, 32'h11},
    '{8'h0, 32'h0800_0a00, 5'd0, 32'h21}};
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  monitor_pkg::wb_req_s wb_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic pulse_input_one;
  logic pulse_input_two;
  logic serial_rx;
  monitor_pkg::adc_s adc_i;
  logic analog_supply_on;
  logic error_out;
  logic [15:0] target_speed;
  logic pulse_en = 1'b0;
  logic adc_en = 1'b0;
  logic pot_connected = 1'b1;
  logic aa_go = 1'b0;
  logic [3:0][11:0] adc_val = {12'h100, 12'h800, 12'h800, 12'h800};
  logic [31:0] rd;
  logic [31:0] up;
  logic ok;
  int num_errors = 0;
  int checked = 0;

  always #5 sys_clk = ~sys_clk;

  motor_input_channel_monitor #(.MS_CYCLES(20)) u_dut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wb_i(wb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .pulse_input_one(pulse_input_one),
    .pulse_input_two(pulse_input_two),
    .serial_rx(serial_rx),
    .adc_i(adc_i),
    .analog_supply_on(analog_supply_on),
    .error_out(error_out),
    .target_speed(target_speed)
  );

  far_side_model u_far (
    .sys_clk(sys_clk),
    .pulse_en(pulse_en),
    .adc_en(adc_en),
    .pot_connected(pot_connected),
    .aa_go(aa_go),
    .adc_val(adc_val),
    .analog_supply_on(analog_supply_on),
    .pulse_input_one(pulse_input_one),
    .pulse_input_two(pulse_input_two),
    .serial_rx(serial_rx),
    .adc_i(adc_i)
  );

  // ----------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  // Request stays up until ack is sampled; the next call idles one cycle first
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_i <= '{1'b1, 1'b1, we, 4'hf, adr, wd};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_i <= '0;
    if (wb_ack_o !== 1'b1)
      check(32'h0, 32'h1);
  endtask

  task automatic chk_rd(input logic [7:0] adr, input logic [31:0] want);
    wb(1'b0, adr, 32'h0);
    check(rd, want);
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      chk_rd(RST_ROWS[i].adr, RST_ROWS[i].want);
    $display("Reset values done");
    // Low supply threshold stays 0 until the averages have settled
    wb(1'b1, 8'h18, 32'h0014_0002);
    wb(1'b1, 8'h10, 32'h0c00_0000);
    wb(1'b1, 8'h14, 32'h0000_0800);
    wb(1'b1, 8'h78, 32'h0100_0100);
    wb(1'b1, 8'h68, 32'h0000_0700);
    pulse_en <= 1'b1;
    adc_en <= 1'b1;
    wb(1'b0, 8'h1c, 32'h0);
    up = rd;
    repeat (200) @(posedge sys_clk);
    wb(1'b0, 8'h1c, 32'h0);
    check({31'h0, (rd - up) >= 32'd9 && (rd - up) <= 32'd11}, 32'h1);
    wb(1'b1, 8'h10, 32'h0c00_0400);
    $display("Up time done");
    for (int i = 0; i < 7; i++)
    begin
      wb(1'b1, LIM_ROWS[i].adr, LIM_ROWS[i].val);
      repeat (3000) @(posedge sys_clk);
      wb(1'b0, 8'h40, 32'h0);
      check((rd >> LIM_ROWS[i].sh) & 32'h7, LIM_ROWS[i].want);
    end
    wb(1'b0, 8'h30, 32'h0);
    check({31'h0, rd[15:0] >= 16'd39 && rd[15:0] <= 16'd41}, 32'h1);
    wb(1'b0, 8'h24, 32'h0);
    check({31'h0, rd >= 32'd99 && rd <= 32'd101}, 32'h1);
    chk_rd(8'h38, 32'h0100_0800);
    wb(1'b1, 8'h68, 32'h0);
    wb(1'b1, 8'h78, 32'h0200_0200);
    repeat (10) @(posedge sys_clk);
    chk_rd(8'h38, 32'h0c80_0800);
    $display("Channel readout done");
    pot_connected <= 1'b0;
    repeat (1000) @(posedge sys_clk);
    wb(1'b0, 8'h40, 32'h0);
    check((rd >> 6) & 32'h7, 32'h1);
    pot_connected <= 1'b1;
    wb(1'b1, 8'h00, 32'h0000_0004);
    repeat (4) @(posedge sys_clk);
    ok = 1'b1;
    repeat (100)
    begin
      @(posedge sys_clk);
      ok = ok & analog_supply_on;
    end
    check({31'h0, ok}, 32'h1);
    wb(1'b1, 8'h00, 32'h0000_000c);
    $display("Disconnect detection done");
    for (int i = 0; i < 3; i++)
    begin
      adc_val[2] <= ERR_ROWS[i].val[27:16];
      adc_val[3] <= ERR_ROWS[i].val[11:0];
      repeat (400) @(posedge sys_clk);
      chk_rd(8'h0c, ERR_ROWS[i].want);
      check({31'h0, error_out}, 32'h1);
      adc_val[2] <= 12'h800;
      adc_val[3] <= 12'h100;
      repeat (400) @(posedge sys_clk);
      chk_rd(8'h0c, 32'h1);
      wb(1'b1, 8'h04, 32'h1);
      repeat (8) @(posedge sys_clk);
      chk_rd(8'h0c, 32'h0);
      check({31'h0, error_out}, 32'h0);
    end
    $display("Condition errors done");
    wb(1'b1, 8'h08, 32'h0100);
    repeat (4) @(posedge sys_clk);
    check({16'h0, target_speed}, 32'h0100);
    adc_val[2] <= 12'h200;
    repeat (400) @(posedge sys_clk);
    wb(1'b1, 8'h08, 32'h0300);
    check({16'h0, target_speed}, 32'h0);
    adc_val[2] <= 12'h800;
    repeat (400) @(posedge sys_clk);
    wb(1'b1, 8'h04, 32'h1);
    repeat (8) @(posedge sys_clk);
    check({16'h0, target_speed}, 32'h0);
    wb(1'b1, 8'h08, 32'h0100);
    repeat (4) @(posedge sys_clk);
    check({16'h0, target_speed}, 32'h0100);
    wb(1'b1, 8'h04, 32'h2);
    repeat (8) @(posedge sys_clk);
    chk_rd(8'h0c, 32'h1);
    check({16'h0, target_speed}, 32'h0);
    chk_rd(8'h80, 32'h5);
    chk_rd(8'h8c, 32'h2);
    chk_rd(8'h90, 32'h1);
    chk_rd(8'h94, 32'h1);
    $display("Manual speed and counts done");
    wb(1'b1, 8'h00, 32'h0000_004d);
    repeat (8) @(posedge sys_clk);
    chk_rd(8'h0c, 32'h1);
    wb(1'b1, 8'h68, 32'h0000_07f0);
    repeat (8) @(posedge sys_clk);
    chk_rd(8'h0c, 32'h0);
    check({16'h0, target_speed}, 32'h0020);
    wb(1'b1, 8'h58, 32'h0700_0100);
    repeat (8) @(posedge sys_clk);
    chk_rd(8'h0c, 32'h3);
    check({31'h0, error_out}, 32'h1);
    wb(1'b1, 8'h58, 32'h0f00_0100);
    wb(1'b1, 8'h00, 32'h0000_040d);
    repeat (8) @(posedge sys_clk);
    chk_rd(8'h0c, 32'h0);
    wb(1'b1, 8'h68, 32'h0);
    repeat (8) @(posedge sys_clk);
    chk_rd(8'h0c, 32'h5);
    wb(1'b1, 8'h68, 32'h0000_07f0);
    repeat (8) @(posedge sys_clk);
    chk_rd(8'h0c, 32'h0);
    $display("Input modes done");
    aa_go <= 1'b1;
    repeat (1200) @(posedge sys_clk);
    chk_rd(8'h20, 32'd87);
    $display("Auto baud done");
    wrap_up();
  end
endmodule
